// ===== tmr_pkg.sv
// Shared constants, types and decoding for the three-channel timer block
package tmr_pkg;

  localparam int unsigned NUM_TIMERS = 3;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned BYTE_W     = 8;

  // Register map
  localparam logic [3:0] ADDR_CTRL_BASE  = 4'h0;
  localparam logic [3:0] ADDR_STATUS     = 4'h3;
  localparam logic [3:0] ADDR_LATCH_BASE = 4'h4;
  localparam logic [3:0] ADDR_MASK       = 4'ha;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;
  localparam logic [15:0] LATCH_MAX    = 16'hffff;
  localparam logic [15:0] CNT_RESET    = 16'hffff;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [15:0] WORD_ONE     = 16'h0001;
  localparam int unsigned STATUS_INT_BIT = 7;
  localparam int unsigned INT_RESET_TIMER = 0;

  // Control register layout, one per timer
  typedef struct packed {
    logic pin_drive_enable;
    logic irq_enable_bit;
    logic mode_variant_bit;
    logic mode_modifier_bit;
    logic mode_group_select;
    logic split_count_select;
    logic clock_source_select;
    logic internal_reset_bit;
  } tmr_ctrl_t;

  typedef enum logic [1:0] {
    TMR_CONTINUOUS  = 2'b00,
    TMR_SINGLE_SHOT = 2'b01,
    TMR_FREQ_CMP    = 2'b10,
    TMR_PULSE_CMP   = 2'b11
  } tmr_mode_t;

  // Mode from group, modifier and variant bits
  function automatic tmr_mode_t tmr_decode_mode(input tmr_ctrl_t c);
    tmr_mode_t m;
    m = TMR_CONTINUOUS;
    if (!c.mode_group_select) begin
      m = c.mode_variant_bit ? TMR_SINGLE_SHOT : TMR_CONTINUOUS;
    end else begin
      m = c.mode_modifier_bit ? TMR_PULSE_CMP : TMR_FREQ_CMP;
    end
    return m;
  endfunction

endpackage

// ===== tmr_sync.sv
// Two-stage synchroniser for asynchronous pins
module tmr_sync
  import tmr_pkg::*;
#(
  parameter int unsigned WIDTH     = 1,
  parameter logic        RESET_VAL = 1'b1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  always_comb begin
    stage1_next = async_i;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage1_reg <= {WIDTH{RESET_VAL}};
      sync_o     <= {WIDTH{RESET_VAL}};
    end else if (ce_i) begin
      stage1_reg <= stage1_next;
      sync_o     <= stage2_next;
    end
  end

endmodule

// ===== tmr_core.sv
// Three-channel timer: registers, counter initialization, continuous mode
module tmr_core
  import tmr_pkg::*;
#(
  parameter int unsigned N_TMR = NUM_TIMERS
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   irq_o,
  input  wire logic              external_reset_n_i,
  input  wire logic [N_TMR-1:0]  gate_n_i,
  input  wire logic [N_TMR-1:0]  external_count_clock_n_i,
  output logic      [N_TMR-1:0]  timer_wave_pin_o
);

  function automatic logic [ADDR_W-1:0] latch_addr(input int unsigned idx,
                                                   input logic lsb);
    return ADDR_W'(ADDR_LATCH_BASE + ADDR_W'(2 * idx) + ADDR_W'(lsb));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic              ext_rst_n_s;
  logic [N_TMR-1:0]  gate_n_s;
  logic [N_TMR-1:0]  cnt_clk_n_s;

  tmr_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_rst (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i (external_reset_n_i),
    .sync_o  (ext_rst_n_s)
  );

  tmr_sync #(.WIDTH(N_TMR), .RESET_VAL(1'b1)) u_sync_gate (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i (gate_n_i),
    .sync_o  (gate_n_s)
  );

  tmr_sync #(.WIDTH(N_TMR), .RESET_VAL(1'b1)) u_sync_clk (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i (external_count_clock_n_i),
    .sync_o  (cnt_clk_n_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register file, status flags and interrupt
  tmr_ctrl_t         ctrl_reg   [N_TMR];
  tmr_ctrl_t         ctrl_next  [N_TMR];
  logic [CNT_W-1:0]  latch_reg  [N_TMR];
  logic [CNT_W-1:0]  latch_next [N_TMR];
  logic [CNT_W-1:0]  cnt_reg    [N_TMR];
  logic [N_TMR-1:0]  flag_reg;
  logic [N_TMR-1:0]  flag_next;
  logic [N_TMR-1:0]  mask_reg;
  logic [N_TMR-1:0]  mask_next;
  logic [N_TMR-1:0]  irq_en;
  logic [N_TMR-1:0]  latch_wr;
  logic [DATA_W-1:0] rdata_next;
  logic              irq_next;
  logic              reset_cond;
  wire  [N_TMR-1:0]  init_w;
  wire  [N_TMR-1:0]  timeout_w;

  assign reset_cond = !ext_rst_n_s
                    || ctrl_reg[INT_RESET_TIMER].internal_reset_bit;

  always_comb begin
    flag_next  = flag_reg;
    mask_next  = mask_reg;
    rdata_next = ZERO_BYTE;
    irq_en     = '0;
    latch_wr   = '0;
    if (wr_i && addr_i == ADDR_MASK) begin
      mask_next = wdata_i[N_TMR-1:0];
    end
    if (rd_i && addr_i == ADDR_STATUS) begin
      rdata_next[N_TMR-1:0]      = flag_reg;
      rdata_next[STATUS_INT_BIT] = irq_o;
    end
    if (rd_i && addr_i == ADDR_MASK) begin
      rdata_next[N_TMR-1:0] = mask_reg;
    end
    for (int unsigned i = 0; i < N_TMR; i++) begin
      ctrl_next[i]  = ctrl_reg[i];
      latch_next[i] = latch_reg[i];
      irq_en[i]     = ctrl_reg[i].irq_enable_bit;
      if (wr_i && addr_i == ADDR_W'(ADDR_CTRL_BASE + ADDR_W'(i))) begin
        ctrl_next[i] = tmr_ctrl_t'(wdata_i);
      end
      if (wr_i && addr_i == latch_addr(i, 1'b0)) begin
        latch_next[i][CNT_W-1:BYTE_W] = wdata_i;
      end
      if (wr_i && addr_i == latch_addr(i, 1'b1)) begin
        latch_next[i][BYTE_W-1:0] = wdata_i;
        latch_wr[i]               = 1'b1;
      end
      if (!ext_rst_n_s) begin
        latch_next[i] = LATCH_MAX;
      end
      if (rd_i && addr_i == ADDR_W'(ADDR_CTRL_BASE + ADDR_W'(i))) begin
        rdata_next = ctrl_reg[i];
      end
      if (rd_i && addr_i == latch_addr(i, 1'b0)) begin
        rdata_next = cnt_reg[i][CNT_W-1:BYTE_W];
      end
      if (rd_i && addr_i == latch_addr(i, 1'b1)) begin
        rdata_next = cnt_reg[i][BYTE_W-1:0];
      end
      if (wr_i && addr_i == ADDR_STATUS && wdata_i[i]) begin
        flag_next[i] = 1'b0;
      end
      if (init_w[i]) begin
        flag_next[i] = 1'b0;
      end
      if (timeout_w[i]) begin
        flag_next[i] = 1'b1;
      end
    end
    irq_next = |(flag_next & mask_next & irq_en);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int unsigned i = 0; i < N_TMR; i++) begin
        ctrl_reg[i]  <= tmr_ctrl_t'(CTRL_RESET);
        latch_reg[i] <= LATCH_MAX;
      end
      flag_reg <= '0;
      mask_reg <= N_TMR'(MASK_RESET);
      rdata_o  <= ZERO_BYTE;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      for (int unsigned i = 0; i < N_TMR; i++) begin
        ctrl_reg[i]  <= ctrl_next[i];
        latch_reg[i] <= latch_next[i];
      end
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      rdata_o  <= rdata_next;
      irq_o    <= irq_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-timer counter and wave generation
  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    tmr_mode_t        mode;
    logic             gate_d_reg;
    logic             clk_d_reg;
    logic             wave_reg;
    logic             fired_reg;
    logic             gate_d_next;
    logic             clk_d_next;
    logic             wave_next;
    logic             fired_next;
    logic             pin_next;
    logic [CNT_W-1:0] cnt_next;
    logic             gate_fall;
    logic             tick;
    logic             count_en;
    logic             step_w;
    logic             init_l;
    logic             timeout_l;
    logic             synth;
    logic             msb_zero;

    assign mode      = tmr_decode_mode(ctrl_reg[g]);
    assign synth     = !ctrl_reg[g].mode_group_select;
    assign gate_fall = gate_d_reg && !gate_n_s[g];
    assign tick      = ctrl_reg[g].clock_source_select
                     || (clk_d_reg && !cnt_clk_n_s[g]);
    assign count_en  = (mode == TMR_CONTINUOUS) ? !gate_n_s[g] : 1'b1;
    assign step_w    = tick && count_en && !reset_cond;
    assign init_l    = reset_cond
                     || (synth && gate_fall)
                     || (synth && latch_wr[g]
                         && !ctrl_reg[g].mode_modifier_bit);
    assign init_w[g]    = init_l;
    assign timeout_w[g] = timeout_l;

    always_comb begin
      gate_d_next = gate_n_s[g];
      clk_d_next  = cnt_clk_n_s[g];
      cnt_next    = cnt_reg[g];
      wave_next   = wave_reg;
      fired_next  = fired_reg;
      timeout_l   = 1'b0;
      msb_zero    = 1'b0;
      if (init_l) begin
        cnt_next   = latch_next[g];
        wave_next  = 1'b0;
        fired_next = 1'b0;
      end
      if (step_w) begin
        msb_zero = (cnt_next[CNT_W-1:BYTE_W] == ZERO_BYTE);
        if (cnt_next == ZERO_WORD) begin
          timeout_l  = 1'b1;
          cnt_next   = latch_next[g];
          fired_next = 1'b1;
          if (ctrl_reg[g].split_count_select
              && latch_next[g][BYTE_W-1:0] != ZERO_BYTE) begin
            wave_next = 1'b0;
          end else begin
            wave_next = !wave_reg;
          end
        end else if (ctrl_reg[g].split_count_select) begin
          if (cnt_next[BYTE_W-1:0] == ZERO_BYTE) begin
            cnt_next = {BYTE_W'(cnt_next[CNT_W-1:BYTE_W] - BYTE_ONE),
                        latch_next[g][BYTE_W-1:0]};
          end else begin
            cnt_next[BYTE_W-1:0] =
              BYTE_W'(cnt_next[BYTE_W-1:0] - BYTE_ONE);
          end
          if (msb_zero) begin
            wave_next = 1'b1;
          end
        end else begin
          cnt_next = CNT_W'(cnt_next - WORD_ONE);
        end
      end
      if (mode == TMR_SINGLE_SHOT) begin
        pin_next = !fired_next && latch_next[g] != ZERO_WORD;
      end else begin
        pin_next = wave_next;
      end
      pin_next = pin_next && ctrl_reg[g].pin_drive_enable;
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        gate_d_reg          <= 1'b1;
        clk_d_reg           <= 1'b1;
        cnt_reg[g]          <= CNT_RESET;
        wave_reg            <= 1'b0;
        fired_reg           <= 1'b0;
        timer_wave_pin_o[g] <= 1'b0;
      end else if (ce_i) begin
        gate_d_reg          <= gate_d_next;
        clk_d_reg           <= clk_d_next;
        cnt_reg[g]          <= cnt_next;
        wave_reg            <= wave_next;
        fired_reg           <= fired_next;
        timer_wave_pin_o[g] <= pin_next;
      end
    end

    a_init_loads_latch: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && init_l && !step_w |=> cnt_reg[g] == latch_reg[g])
      else $error("Counter not loaded from latch on initialization");

    a_init_clears_flag: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && init_l && !timeout_l |=> !flag_reg[g])
      else $error("Flag not cleared by initialization");

    a_reset_holds_preset: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && reset_cond |=> cnt_reg[g] == latch_reg[g])
      else $error("Reset condition did not preset the counter");

    a_timeout_sets_flag: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && step_w && !init_l && cnt_reg[g] == ZERO_WORD
      |=> flag_reg[g] && cnt_reg[g] == latch_reg[g])
      else $error("Time-out did not set flag and reload");

    a_latch_write_init: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && mode == TMR_CONTINUOUS && wr_i && !reset_cond
      && addr_i == latch_addr(g, 1'b1)
      && !ctrl_reg[g].mode_modifier_bit && !step_w
      |=> cnt_reg[g] == latch_reg[g])
      else $error("Latch write did not initialize the counter");

    a_gate_high_holds: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && mode == TMR_CONTINUOUS && gate_n_s[g] && !init_l
      |=> $stable(cnt_reg[g]))
      else $error("Counter moved with gate high");

    a_count_decrements: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && step_w && !init_l && !ctrl_reg[g].split_count_select
      && cnt_reg[g] != ZERO_WORD
      |=> cnt_reg[g] == CNT_W'($past(cnt_reg[g]) - WORD_ONE))
      else $error("Counter did not decrement by one");

    a_split_reload: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && step_w && !init_l && ctrl_reg[g].split_count_select
      && cnt_reg[g] != ZERO_WORD
      && cnt_reg[g][BYTE_W-1:0] == ZERO_BYTE
      |=> cnt_reg[g][BYTE_W-1:0] == latch_reg[g][BYTE_W-1:0]
      && cnt_reg[g][CNT_W-1:BYTE_W] ==
         BYTE_W'($past(cnt_reg[g][CNT_W-1:BYTE_W]) - BYTE_ONE))
      else $error("Split low byte reload or high byte step wrong");

    a_pin_masked: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && !ctrl_reg[g].pin_drive_enable |=> !timer_wave_pin_o[g])
      else $error("Wave pin driven while pin drive disabled");

    a_gate_edge_once: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ce_i && gate_fall |=> !gate_fall)
      else $error("One gate edge recognised twice");
  end

endmodule

// ===== tmr_cpu_model.sv
// Host processor model: drives register writes and reads on the timer bus
module tmr_cpu_model
  import tmr_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   wr_o,
  output logic                   rd_o,
  input  wire logic [DATA_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
////////////////////////////////////////
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Idle bus lines show the inverse, never a stale copy
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ===== tb.sv
// Self-checking testbench for the timer core in continuous and single-shot modes
module tb
  import tmr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i = 1'b0;
  logic              reset_i;
  logic              ce_i;
  logic              ext_rst_n;
  logic [2:0]        gate_n;
  logic [2:0]        cclk_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic [2:0]        pins;
  int                miscompares = 0;
  int                n_checks = 0;

  always #20 clk_i = ~clk_i;

  tmr_core #(.N_TMR(3)) dut_u (
    .clk_i                    (clk_i),
    .reset_i                  (reset_i),
    .ce_i                     (ce_i),
    .addr_i                   (addr),
    .wdata_i                  (wdata),
    .wr_i                     (wr),
    .rd_i                     (rd),
    .rdata_o                  (rdata),
    .irq_o                    (irq),
    .external_reset_n_i       (ext_rst_n),
    .gate_n_i                 (gate_n),
    .external_count_clock_n_i (cclk_n),
    .timer_wave_pin_o         (pins)
  );

  tmr_cpu_model cpu_u (
    .clk_i   (clk_i),
    .addr_o  (addr),
    .wdata_o (wdata),
    .wr_o    (wr),
    .rd_o    (rd),
    .rdata_i (rdata)
  );
////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
    logic [7:0] d;
    cpu_u.rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Cycles between two rising edges of the timer 1 wave pin
  task automatic period(output logic [15:0] n);
    logic p;
    int   k;
    k = 0;
    do begin
      p = pins[1];
      @(posedge clk_i);
      k++;
    end while (k < 200 && !(p === 1'b0 && pins[1] === 1'b1));
    n = 16'h0000;
    do begin
      p = pins[1];
      @(posedge clk_i);
      n++;
    end while (n < 200 && !(p === 1'b0 && pins[1] === 1'b1));
  endtask

  task automatic pulse_cclk(input int n);
    repeat (n) begin
      cclk_n[1] <= 1'b0;
      cyc(4);
      cclk_n[1] <= 1'b1;
      cyc(4);
    end
  endtask
////////////////////////////////////////
  task automatic t_reset_values;
    chk("pins", 16'h0000, {13'h0000, pins});
    chk("irq", 16'h0000, {15'h0000, irq});
    rchk("ctrl1", 4'h1, 8'h00);
    rchk("status", 4'h3, 8'h00);
    rchk("cnt1 msb", 4'h6, 8'hff);
    rchk("cnt1 lsb", 4'h7, 8'hff);
    cpu_u.wr(4'hc, 8'h5a);
    rchk("unmapped", 4'hc, 8'h00);
  endtask

  task automatic t_waves;
    logic [15:0] n;
    logic [7:0]  a;
    logic [7:0]  b;
    gate_n <= 3'b101;
    cpu_u.wr(4'h1, 8'hc2);
    cpu_u.wr(4'h6, 8'h00);
    cpu_u.wr(4'h7, 8'h02);
    period(n);
    chk("square period", 16'd6, n);
    cpu_u.wr(4'h1, 8'hc6);
    cpu_u.wr(4'h6, 8'h01);
    cpu_u.wr(4'h7, 8'h01);
    period(n);
    chk("split period", 16'd4, n);
    gate_n <= 3'b111;
    cyc(8);
    cpu_u.rd(4'h7, a);
    cyc(5);
    cpu_u.rd(4'h7, b);
    chk("held count", {8'h00, a}, {8'h00, b});
    rchk("flag set", 4'h3, 8'h02);
    cyc(3);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    cpu_u.wr(4'ha, 8'h02);
    cyc(3);
    chk("irq on", 16'h0001, {15'h0000, irq});
    rchk("status int", 4'h3, 8'h82);
    cpu_u.wr(4'h6, 8'h00);
    cpu_u.wr(4'h7, 8'h40);
    cyc(3);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rchk("flag cleared", 4'h3, 8'h00);
    rchk("init lsb", 4'h7, 8'h40);
  endtask

  task automatic t_gate_init;
    cpu_u.wr(4'h1, 8'h10);
    cyc(3);
    chk("pin off", 16'h0000, {15'h0000, pins[1]});
    cpu_u.wr(4'h6, 8'h00);
    cpu_u.wr(4'h7, 8'h20);
    rchk("no write init", 4'h7, 8'h40);
    gate_n <= 3'b101;
    cyc(6);
    rchk("gate init", 4'h7, 8'h20);
    pulse_cclk(2);
    rchk("ext count", 4'h7, 8'h1e);
  endtask

  task automatic t_resets;
    cpu_u.wr(4'h0, 8'h01);
    cyc(3);
    rchk("int reset", 4'h7, 8'h20);
    pulse_cclk(2);
    rchk("reset hold", 4'h7, 8'h20);
    cpu_u.wr(4'h0, 8'h00);
    ext_rst_n <= 1'b0;
    cyc(6);
    rchk("ext rst msb", 4'h6, 8'hff);
    rchk("ext rst lsb", 4'h7, 8'hff);
    ext_rst_n <= 1'b1;
    cyc(4);
    rchk("ctrl kept", 4'h1, 8'h10);
  endtask

  // Single-shot counts with the gate high; a low clock enable freezes it
  task automatic t_modes;
    gate_n <= 3'b111;
    cpu_u.wr(4'h1, 8'h22);
    cpu_u.wr(4'h6, 8'h00);
    cpu_u.wr(4'h7, 8'h40);
    ce_i <= 1'b0;
    cyc(5);
    ce_i <= 1'b1;
    rchk("single shot", 4'h7, 8'h3e);
  endtask
////////////////////////////////////////
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end

  initial begin
    reset_i   = 1'b1;
    ce_i      = 1'b1;
    ext_rst_n = 1'b1;
    gate_n    = 3'b111;
    cclk_n    = 3'b111;
    cyc(8);
    reset_i <= 1'b0;
    t_reset_values();
    t_waves();
    t_gate_init();
    t_resets();
    t_modes();
    end_sim();
  end
endmodule
